// file: pkg/dsc_defines.vh
/*
 Constants for the serial converter command port controller: register
 offsets of the Wishbone slave, frame layout, command codes and serial
 timing counts. Assumes a 20 MHz system clock.
*/
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH

// Wishbone register offsets (byte addresses)
`define DSC_ADDR_CTRL      4'h0
`define DSC_ADDR_DATA      4'h4
`define DSC_ADDR_STAT      4'h8
`define DSC_ADDR_SHADOW    4'hC

// Control register fields
`define DSC_CTRL_GO_BIT    0
`define DSC_CTRL_CMD_LSB   4
`define DSC_CTRL_CMD_MSB   6
`define DSC_CTRL_SEL_LSB   8
`define DSC_CTRL_SEL_MSB   9

// Status register fields
`define DSC_STAT_BUSY_BIT  0
`define DSC_STAT_DONE_BIT  1
`define DSC_STAT_SHDN_BIT  2

// Frame layout, most significant bit first
`define DSC_FRAME_BITS     16
`define DSC_CODE_BITS      10
`define DSC_CMD_LSB        13
`define DSC_CODE_LSB       3
`define DSC_SUB_ZERO       3'h0

// Command codes
`define DSC_CMD_LOAD_UPD   3'h0
`define DSC_CMD_LOAD_IN    3'h1
`define DSC_CMD_UPDATE     3'h2
`define DSC_CMD_NO_OPERATION 3'h3
`define DSC_CMD_SHDN       3'h7

// Reset values
`define DSC_CODE_RST       10'h000
`define DSC_CMD_RST        3'h3

// Serial timing: times in ns, counts derived from the 50 ns clock
`define DSC_CLK_NS         50
`define DSC_SCLK_HALF_NS   100
`define DSC_SEL_HIGH_NS    100
`define DSC_SCLK_HALF_CYC \
  ((`DSC_SCLK_HALF_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_SEL_HIGH_CYC \
  ((`DSC_SEL_HIGH_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_DEV_COUNT      4

`endif

// file: verilog/dsc_shifter.v
/*
 Serial shifter: sends one 16-bit frame MSB first on a divided serial
 clock with an active-low select. Data changes on the falling clock
 and is stable across the rising edge, where the device samples it.
 Assumes a single system clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
`include "dsc_defines.vh"

module dsc_shifter (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire [15:0] frame_i,
  output wire        busy_o,
  output reg         done_o,
  output reg         sclk_o,
  output reg         sdata_o,
  output reg         sel_n_o
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_SETUP = 4'b0010;
  localparam [3:0] ST_SHIFT = 4'b0100;
  localparam [3:0] ST_GAP   = 4'b1000;

  reg [3:0]  state_q;
  reg [15:0] sreg_q;
  reg [4:0]  bit_q;
  reg [2:0]  tmr_q;

  assign busy_o = ~state_q[0];

  // Half-period timer paces the serial clock at 5 MHz, below 10 MHz
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      state_q <= ST_IDLE;
      sreg_q  <= 16'h0000;
      bit_q   <= 5'h00;
      tmr_q   <= 3'h0;
      sclk_o  <= 1'b0;
      sdata_o <= 1'b0;
      sel_n_o <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sclk_o <= 1'b0;
          if (start_i) begin
            sreg_q  <= frame_i;
            sel_n_o <= 1'b0;
            sdata_o <= frame_i[15];
            bit_q   <= 5'h00;
            tmr_q   <= 3'h0;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Select leads the first rising edge by two half periods, this one and the first shift wait
          if (tmr_q == `DSC_SCLK_HALF_CYC - 1) begin
            tmr_q   <= 3'h0;
            state_q <= ST_SHIFT;
          end else begin
            tmr_q <= tmr_q + 3'h1;
          end
        end
        ST_SHIFT: begin
          if (tmr_q == `DSC_SCLK_HALF_CYC - 1) begin
            tmr_q  <= 3'h0;
            sclk_o <= ~sclk_o;
            if (sclk_o) begin
              // Falling edge: next bit, or close after bit sixteen
              if (bit_q == `DSC_FRAME_BITS - 1) begin
                state_q <= ST_GAP;
              end else begin
                bit_q   <= bit_q + 5'h01;
                sreg_q  <= {sreg_q[14:0], 1'b0};
                sdata_o <= sreg_q[14];
              end
            end
          end else begin
            tmr_q <= tmr_q + 3'h1;
          end
        end
        ST_GAP: begin
          // Select rise latches the word; hold it high the minimum width
          sel_n_o <= 1'b1;
          if (tmr_q == `DSC_SEL_HIGH_CYC) begin
            done_o  <= 1'b1;
            tmr_q   <= 3'h0;
            state_q <= ST_IDLE;
          end else begin
            tmr_q <= tmr_q + 3'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // dsc_shifter

// file: verilog/dsc_host.v
/*
 Host controller for a serial 10-bit converter command port. Software
 writes a command, a code and a device select over classic Wishbone,
 then sets go; the block sends one 16-bit frame on the shared serial
 clock and data lines with the addressed device's select. It keeps a
 shadow of each device's registers and power state for readback.
 Assumes one 20 MHz clock, synchronous active-high reset, and up to
 four converters that share the serial clock and data lines, each with
 its own active-low select. There is no interrupt: software polls the
 status word until done is set. A go written while a frame is in flight
 is dropped without an error, so software must wait for done first.
 The shadow copies mirror what each converter should hold; they are
 never read back from the link, so a converter that missed a frame
 will disagree with its shadow silently.
*/
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`include "dsc_defines.vh"

module dsc_host (
  input  wire        clk_i,
  input  wire        rst_i,
  // Classic Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Serial link to the converters
  output wire        sclk_o,
  output wire        sdata_o,
  output wire [3:0]  sel_n_o
);

  reg  [2:0]  cmd_q;
  reg  [9:0]  code_q;
  reg  [1:0]  dev_q;
  reg  [1:0]  act_dev_q;
  reg         go_q;
  reg         done_q;
  reg         ack_q;
  reg  [9:0]  in_q   [0:`DSC_DEV_COUNT-1];
  reg  [9:0]  conv_q [0:`DSC_DEV_COUNT-1];
  reg  [`DSC_DEV_COUNT-1:0] shdn_q;
  reg  [15:0] frame_q;
  wire        busy;
  wire        sent;
  wire        sh_sel_n;
  wire        wb_req;
  wire        wr_ctrl;
  wire        wr_data;
  wire        cmd_shdn;
  wire        cmd_load_upd;
  wire        cmd_load_in;
  wire        cmd_update;
  wire [9:0]  sent_code;
  wire [31:0] stat_word;

  // Bus decode; a write lands on the edge that raises ack, once per ack
  assign wb_req  = wb_cyc_i & wb_stb_i;
  assign wb_ack_o = ack_q;
  assign wr_ctrl = wb_req & ~ack_q & wb_we_i & (wb_adr_i == `DSC_ADDR_CTRL);
  assign wr_data = wb_req & ~ack_q & wb_we_i & (wb_adr_i == `DSC_ADDR_DATA);

  // Decode of the frame last sent; bit 15 only tells shutdown from no-op
  assign cmd_shdn     = (frame_q[15:`DSC_CMD_LSB] == `DSC_CMD_SHDN);
  assign cmd_load_upd = (frame_q[14:`DSC_CMD_LSB] == 2'h0);
  assign cmd_load_in  = (frame_q[14:`DSC_CMD_LSB] == 2'h1);
  assign cmd_update   = (frame_q[14:`DSC_CMD_LSB] == 2'h2);
  assign sent_code    = frame_q[`DSC_CMD_LSB-1:`DSC_CODE_LSB];

  // Status word: shutdown shadow of the selected device, done, busy
  assign stat_word = {29'h0000000, shdn_q[dev_q], done_q, busy};

  // One-cycle ack, one cycle after the request edge; dropped the next
  // cycle, so a master that still holds cyc is acked again every second cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req & ~ack_q;
    end
  end

  // Register writes; go is ignored while a frame is in flight
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q     <= `DSC_CMD_RST;
      code_q    <= `DSC_CODE_RST;
      dev_q     <= 2'h0;
      act_dev_q <= 2'h0;
      go_q      <= 1'b0;
      frame_q   <= 16'h0000;
    end else begin
      go_q <= 1'b0;
      if (wr_data && wb_sel_i[0]) begin
        code_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_data && wb_sel_i[1]) begin
        code_q[9:8] <= wb_dat_i[9:8];
      end
      if (wr_ctrl && wb_sel_i[0]) begin
        cmd_q <= wb_dat_i[`DSC_CTRL_CMD_MSB:`DSC_CTRL_CMD_LSB];
        // Go is dropped while busy or pending; the frame keeps its copy
        // of command, code and device so later writes cannot disturb it
        if (wb_dat_i[`DSC_CTRL_GO_BIT] && !busy && !go_q) begin
          go_q      <= 1'b1;
          frame_q   <= {wb_dat_i[`DSC_CTRL_CMD_MSB:`DSC_CTRL_CMD_LSB],
                        code_q, `DSC_SUB_ZERO};
          act_dev_q <= (wb_sel_i[1]) ?
                       wb_dat_i[`DSC_CTRL_SEL_MSB:`DSC_CTRL_SEL_LSB] : dev_q;
        end
      end
      if (wr_ctrl && wb_sel_i[1]) begin
        dev_q <= wb_dat_i[`DSC_CTRL_SEL_MSB:`DSC_CTRL_SEL_LSB];
      end
    end
  end

  // Done is sticky until a new go; a finishing frame wins over the clear
  // Software polls this bit, as there is no interrupt line
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (sent) begin
      done_q <= 1'b1;
    end else if (go_q) begin
      done_q <= 1'b0;
    end
  end

  // Shadow of each device, updated on the done pulse after the select gap at frame end
  genvar g;
  generate
    for (g = 0; g < `DSC_DEV_COUNT; g = g + 1) begin : g_shadow
      always @(posedge clk_i) begin
        if (rst_i) begin
          in_q[g]   <= `DSC_CODE_RST;
          conv_q[g] <= `DSC_CODE_RST;
          shdn_q[g] <= 1'b0;
        end else if (sent && act_dev_q == g) begin
          // Input register is left alone in shutdown for a later recall
          if (cmd_shdn) begin
            shdn_q[g] <= 1'b1;
          end else if (cmd_load_upd) begin
            in_q[g]   <= sent_code;
            conv_q[g] <= sent_code;
            shdn_q[g] <= 1'b0;
          end else if (cmd_load_in) begin
            in_q[g]   <= sent_code;
          end else if (cmd_update) begin
            conv_q[g] <= in_q[g];
            shdn_q[g] <= 1'b0;
          end
          // 011 leaves everything as it was
        end
      end
    end
  endgenerate

  // Read mux; unmapped offsets read zero
  // Data is registered and stands while ack is high
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= 32'h00000000;
      case (wb_adr_i)
        `DSC_ADDR_CTRL:
          wb_dat_o <= {22'h000000, dev_q, 1'b0, cmd_q, 4'h0};
        `DSC_ADDR_DATA:
          wb_dat_o <= {22'h000000, code_q};
        `DSC_ADDR_STAT:
          wb_dat_o <= stat_word;
        `DSC_ADDR_SHADOW:
          wb_dat_o <= {6'h00, conv_q[dev_q], 6'h00, in_q[dev_q]};
        default:
          wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Serial engine; one frame at a time, paced well under ten megahertz
  dsc_shifter u_shifter (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (go_q),
    .frame_i (frame_q),
    .busy_o  (busy),
    .done_o  (sent),
    .sclk_o  (sclk_o),
    .sdata_o (sdata_o),
    .sel_n_o (sh_sel_n)
  );

  // Shared clock and data; only the addressed device sees select low
  generate
    for (g = 0; g < `DSC_DEV_COUNT; g = g + 1) begin : g_sel
      assign sel_n_o[g] = (act_dev_q == g) ? sh_sel_n : 1'b1;
    end
  endgenerate

endmodule // dsc_host

// file: sim/dsc_dev_model.sv
/*
 Behavioural model of one converter command port on the serial link.
 Assumes the host paces select, clock and data as the frame rules ask.
*/
`timescale 1ns/1ns
module dsc_dev_model (
  input  wire logic        sclk_i,
  input  wire logic        sdata_i,
  input  wire logic        sel_n_i,
  output logic      [15:0] word_o,
  output logic      [9:0]  in_o,
  output logic      [9:0]  dac_o,
  output logic             shdn_o
);
  logic [15:0] sh;
  wire  [9:0]  code = sh[12:3];
  // Power-up clears both registers
  initial begin
    in_o = 10'h000;
    dac_o = 10'h000;
    shdn_o = 1'b0;
  end
  // Shifts only while selected, also in shutdown
  always @(posedge sclk_i) begin
    if (!sel_n_i)
      sh <= {sh[14:0], sdata_i};
  end
  // Last sixteen bits acted on at select release; 011 falls through
  always @(posedge sel_n_i) begin
    word_o <= sh;
    if (sh[15:13] == 3'h7)
      shdn_o <= 1'b1;
    else if (sh[14:13] == 2'h0) begin
      in_o <= code;
      dac_o <= code;
      shdn_o <= 1'b0;
    end else if (sh[14:13] == 2'h1)
      in_o <= code;
    else if (sh[14:13] == 2'h2) begin
      dac_o <= in_o;
      shdn_o <= 1'b0;
    end
  end
endmodule // dsc_dev_model

// file: sim/dsc_host_checker.sv
/*
 Assertions on the serial link pacing and Wishbone answer of dsc_host.
 Assumes it is bound to dsc_host and sees only its ports.
*/
`timescale 1ns/1ns
module dsc_host_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       sclk_o,
  input wire logic       sdata_o,
  input wire logic [3:0] sel_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire        idle = &sel_n_o;
  logic [4:0] rises_q;
  // Rising serial edges in the open frame
  always @(posedge clk_i) begin
    if (rst_i || idle)
      rises_q <= 5'h00;
    else if ($rose(sclk_o))
      rises_q <= rises_q + 5'h01;
  end
  sequence s_low2;
    !sclk_o ##1 !sclk_o;
  endsequence
  sequence s_high2;
    sclk_o ##1 sclk_o;
  endsequence
  chk_one_select: assert property ($onehot0(~sel_n_o))
    else $error("two selects low");
  chk_idle_clock: assert property (idle |-> !sclk_o)
    else $error("clock runs while idle");
  chk_frame_len: assert property ($rose(idle) |-> rises_q == 5'h10)
    else $error("frame not sixteen edges");
  // Select leads the first rise by four cycles of low clock
  chk_sel_setup: assert property (
    $fell(idle) |-> s_low2 ##1 s_low2 ##1 sclk_o)
    else $error("select to clock setup");
  chk_sclk_high: assert property ($rose(sclk_o) |-> s_high2 ##1 !sclk_o)
    else $error("clock high time");
  chk_sclk_low: assert property ($fell(sclk_o) |-> s_low2)
    else $error("clock low time");
  chk_data_hold: assert property (sclk_o |-> $stable(sdata_o))
    else $error("data moved while clock high");
  chk_sel_gap: assert property ($rose(idle) |-> idle[*2])
    else $error("select gap too short");
  chk_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
endmodule // dsc_host_checker

bind dsc_host dsc_host_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .sclk_o(sclk_o), .sdata_o(sdata_o), .sel_n_o(sel_n_o));

// file: sim/test_dsc_host.sv
/*
 Self-checking bench for dsc_host driving four device models.
 Assumes a one-cycle Wishbone answer and the link pacing of the notes.
*/
`timescale 1ns/1ns
module test_dsc_host;
  logic        clk_i, rst_i, cyc, stb, we;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, sclk, sdata;
  wire  [3:0]  sel_n;
  wire  [15:0] m_word [0:3];
  wire  [9:0]  m_in [0:3], m_dac [0:3];
  wire         m_shdn [0:3];
  logic [9:0]  e_in [0:3], e_dac [0:3];
  logic        e_sd [0:3];
  int          num_errors, checks_done;
  dsc_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sclk_o(sclk), .sdata_o(sdata), .sel_n_o(sel_n));
  // One model per select; clock and data shared
  for (genvar i = 0; i < 4; i++) begin : g_dev
    dsc_dev_model dev_u (.sclk_i(sclk), .sdata_i(sdata),
      .sel_n_i(sel_n[i]), .word_o(m_word[i]), .in_o(m_in[i]),
      .dac_o(m_dac[i]), .shdn_o(m_shdn[i]));
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle; held until ack is sampled, then a one-cycle gap
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      num_errors++;
      end_of_test();
    end
  endtask
  // Waits for done, then checks every device against the reference
  task automatic settle(input int d, input logic [2:0] c,
                        input logic [9:0] v);
    int n;
    n = 0;
    wb(1'b0, 4'h8, 32'h0);
    cmp("stat busy", 32'h1, {30'h0, rdat[1:0]});
    do begin
      wb(1'b0, 4'h8, 32'h0);
      n++;
    end while (rdat[1:0] !== 2'b10 && n < 200);
    if (n >= 200) begin
      num_errors++;
      end_of_test();
    end
    if (c == 3'h7)
      e_sd[d] = 1'b1;
    else if (c[1:0] == 2'h0) begin
      e_in[d] = v;
      e_dac[d] = v;
      e_sd[d] = 1'b0;
    end else if (c[1:0] == 2'h1)
      e_in[d] = v;
    else if (c[1:0] == 2'h2) begin
      e_dac[d] = e_in[d];
      e_sd[d] = 1'b0;
    end
    cmp("frame", {c, v, 3'h0}, m_word[d]);
    for (int i = 0; i < 4; i++) begin
      cmp("in", e_in[i], m_in[i]);
      cmp("dac", e_dac[i], m_dac[i]);
      cmp("shdn", e_sd[i], m_shdn[i]);
    end
  endtask
  task automatic send(input int d, input logic [2:0] c,
                      input logic [9:0] v);
    wb(1'b1, 4'h4, {22'h0, v});
    wb(1'b1, 4'h0, {22'h0, d[1:0], 1'b0, c, 4'h1});
    settle(d, c, v);
    cmp("stat shdn", e_sd[d], rdat[2]);
    wb(1'b0, 4'hC, 32'h0);
    cmp("shadow", {6'h0, e_dac[d], 6'h0, e_in[d]}, rdat);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      e_in[i] = 10'h000;
      e_dac[i] = 10'h000;
      e_sd[i] = 1'b0;
      cmp("in", 32'h0, m_in[i]);
      cmp("dac", 32'h0, m_dac[i]);
    end
    wb(1'b0, 4'h8, 32'h0);
    cmp("stat", 32'h0, rdat);
    wb(1'b0, 4'hC, 32'h0);
    cmp("shadow", 32'h0, rdat);
    $display("t_reset done");
  endtask
  task automatic t_cmds;
    send(1, 3'h0, 10'h3FF);
    send(1, 3'h1, 10'h155);
    send(1, 3'h3, 10'h0AA);
    send(1, 3'h7, 10'h000);
    send(1, 3'h1, 10'h2AA);
    send(1, 3'h2, 10'h000);
    send(2, 3'h4, 10'h200);
    send(2, 3'h5, 10'h001);
    send(2, 3'h6, 10'h000);
    send(3, 3'h7, 10'h3FF);
    send(3, 3'h0, 10'h1FF);
    $display("t_cmds done");
  endtask
  // Unmapped access, readback, and a go refused while busy
  task automatic t_bus;
    wb(1'b1, 4'h6, 32'h0000_03FF);
    wb(1'b0, 4'h6, 32'h0);
    cmp("unmapped", 32'h0, rdat);
    wb(1'b0, 4'h4, 32'h0);
    cmp("data", 32'h0000_01FF, rdat);
    wb(1'b0, 4'h0, 32'h0);
    cmp("ctrl", 32'h0000_0300, rdat);
    wb(1'b1, 4'h4, 32'h0000_0123);
    wb(1'b1, 4'h0, 32'h0000_0101);
    wb(1'b1, 4'h0, 32'h0000_0001);
    settle(1, 3'h0, 10'h123);
    wb(1'b0, 4'h0, 32'h0);
    cmp("ctrl", 32'h0, rdat);
    $display("t_bus done");
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 4'h0;
    wdat = 32'h0;
    num_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_cmds();
    t_bus();
    end_of_test();
  end
endmodule // test_dsc_host
